/* File: rtl/dcf_pkg.sv */
// shared constants for the dual-clock fifo control block
package dcf_pkg;

    localparam int DATA_W = 18;
    localparam int AW     = 8;
    localparam int CNT_W  = AW + 1;
    localparam int OFS_W  = 12;

    localparam logic [CNT_W-1:0] DEPTH      = 9'h100;
    localparam logic [CNT_W-1:0] HALF_DEPTH = 9'h080;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 9'h000;
    localparam logic [AW-1:0]    ADDR_FIRST = 8'h00;
    localparam logic [AW-1:0]    ADDR_LAST  = 8'hFF;

    // default offset for the 256-word depth; 512 words use 63, larger 127
    localparam logic [OFS_W-1:0]  OFS_DEFAULT = 12'h01F;
    localparam logic [DATA_W-1:0] DOUT_RESET  = 18'h00000;
    localparam logic [5:0]        OFS_PAD     = 6'h00;

    // offset register selector
    localparam logic SEL_EMPTY_OFS = 1'b0;
    localparam logic SEL_FULL_OFS  = 1'b1;

endpackage

/* File: rtl/dcf_mem.sv */
// word storage with registered read data
module dcf_mem (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wr_en_i,
    input  wire logic [dcf_pkg::AW-1:0]    wr_addr_i,
    input  wire logic [dcf_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic [dcf_pkg::AW-1:0]    rd_addr_i,
    output logic      [dcf_pkg::DATA_W-1:0] rd_data_o
);

    logic [dcf_pkg::DATA_W-1:0] mem [2**dcf_pkg::AW];

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_data_o <= dcf_pkg::DOUT_RESET;
        end
        else
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule

/* File: rtl/dcf_fifo_ctrl.sv */
// dual-clock fifo control: pointers, flags, offset registers, chain tokens

module dcf_fifo_ctrl (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        write_clk_i,
    input  wire logic                        write_enable_n_i,
    input  wire logic [dcf_pkg::DATA_W-1:0]  data_in_i,
    input  wire logic                        read_clk_i,
    input  wire logic                        read_enable_n_i,
    input  wire logic                        output_enable_n_i,
    input  wire logic                        load_n_i,
    input  wire logic                        first_load_sel_i,
    input  wire logic                        write_chain_in_n_i,
    input  wire logic                        read_chain_in_n_i,
    output logic      [dcf_pkg::DATA_W-1:0]  data_out_o,
    output logic                             data_out_oe_o,
    output logic                             full_flag_n_o,
    output logic                             empty_flag_n_o,
    output logic                             half_full_flag_n_o,
    output logic                             almost_full_flag_n_o,
    output logic                             almost_empty_flag_n_o,
    output logic                             write_chain_out_n_o,
    output logic                             read_chain_out_n_o
);

    // ----------------------------------------------------------------
    // clock edge detection
    // ----------------------------------------------------------------
    // both port clocks are sampled on clk_i and act only on a rising edge, so a clock held high does nothing more
    logic wclk_reg;
    logic wclk_next;
    logic rclk_reg;
    logic rclk_next;
    logic wr_edge;
    logic rd_edge;

    always_comb
    begin
        wclk_next = write_clk_i;
        rclk_next = read_clk_i;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wclk_reg <= 1'b0;
            rclk_reg <= 1'b0;
        end
        else
        begin
            wclk_reg <= wclk_next;
            rclk_reg <= rclk_next;
        end
    end

    assign wr_edge = write_clk_i & ~wclk_reg;
    assign rd_edge = read_clk_i & ~rclk_reg;

    // ----------------------------------------------------------------
    // pointers, count and chain tokens
    // ----------------------------------------------------------------
    logic [dcf_pkg::CNT_W-1:0] wptr_reg;
    logic [dcf_pkg::CNT_W-1:0] wptr_next;
    logic [dcf_pkg::CNT_W-1:0] rptr_reg;
    logic [dcf_pkg::CNT_W-1:0] rptr_next;
    logic [dcf_pkg::CNT_W-1:0] count;
    logic [dcf_pkg::CNT_W-1:0] count_new;
    logic                      wtok_reg;
    logic                      wtok_next;
    logic                      rtok_reg;
    logic                      rtok_next;
    logic                      init_reg;
    logic                      init_next;
    logic                      wr_fire;
    logic                      rd_fire;
    logic                      full_n_reg;
    logic                      empty_n_reg;

    assign count   = wptr_reg - rptr_reg;
    assign wr_fire = wr_edge & ~write_enable_n_i & load_n_i & full_n_reg & wtok_reg;
    assign rd_fire = rd_edge & ~read_enable_n_i & load_n_i & empty_n_reg & rtok_reg;

    always_comb
    begin
        count_new = count;
        if (wr_fire & ~rd_fire)
        begin
            count_new = count + 9'h001;
        end
        else if (rd_fire & ~wr_fire)
        begin
            count_new = count - 9'h001;
        end
    end

    // extra pointer bit tells full from empty; low bits wrap naturally
    always_comb
    begin
        wptr_next = wptr_reg + {8'h00, wr_fire};
        rptr_next = rptr_reg + {8'h00, rd_fire};
        init_next = 1'b1;
        wtok_next = wtok_reg;
        rtok_next = rtok_reg;
        if (!init_reg)
        begin
            // strap caught on the first edge after reset release
            wtok_next = ~first_load_sel_i;
            rtok_next = ~first_load_sel_i;
        end
        else
        begin
            // a token arriving wins over passing ours on
            if (wr_fire && wptr_reg[dcf_pkg::AW-1:0] == dcf_pkg::ADDR_LAST)
            begin
                wtok_next = 1'b0;
            end
            if (!write_chain_in_n_i)
            begin
                wtok_next = 1'b1;
            end
            if (rd_fire && rptr_reg[dcf_pkg::AW-1:0] == dcf_pkg::ADDR_LAST)
            begin
                rtok_next = 1'b0;
            end
            if (!read_chain_in_n_i)
            begin
                rtok_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wptr_reg <= dcf_pkg::CNT_ZERO;
            rptr_reg <= dcf_pkg::CNT_ZERO;
            init_reg <= 1'b0;
            wtok_reg <= 1'b0;
            rtok_reg <= 1'b0;
        end
        else
        begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            init_reg <= init_next;
            wtok_reg <= wtok_next;
            rtok_reg <= rtok_next;
        end
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // prefetch at the read pointer; port clock edges are at least two cycles apart
    logic [dcf_pkg::DATA_W-1:0] mem_rdata;

    dcf_mem u_mem (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_fire),
        .wr_addr_i (wptr_reg[dcf_pkg::AW-1:0]),
        .wr_data_i (data_in_i),
        .rd_addr_i (rptr_reg[dcf_pkg::AW-1:0]),
        .rd_data_o (mem_rdata)
    );

    // ----------------------------------------------------------------
    // offset registers and output register
    // ----------------------------------------------------------------
    logic [dcf_pkg::OFS_W-1:0]  empty_threshold_offset_reg;
    logic [dcf_pkg::OFS_W-1:0]  empty_threshold_offset_next;
    logic [dcf_pkg::OFS_W-1:0]  full_threshold_offset_reg;
    logic [dcf_pkg::OFS_W-1:0]  full_threshold_offset_next;
    logic                       ofs_wsel_reg;
    logic                       ofs_wsel_next;
    logic                       ofs_rsel_reg;
    logic                       ofs_rsel_next;
    logic [dcf_pkg::DATA_W-1:0] dout_reg;
    logic [dcf_pkg::DATA_W-1:0] dout_next;
    logic                       ofs_wr;
    logic                       ofs_rd;

    // load low with the enable high blocks data and offset access; the port clock edge still refreshes the full or empty flag
    assign ofs_wr = wr_edge & ~load_n_i & ~write_enable_n_i;
    assign ofs_rd = rd_edge & ~load_n_i & ~read_enable_n_i;

    always_comb
    begin
        empty_threshold_offset_next = empty_threshold_offset_reg;
        full_threshold_offset_next  = full_threshold_offset_reg;
        ofs_wsel_next               = ofs_wsel_reg;
        ofs_rsel_next               = ofs_rsel_reg;
        dout_next                   = dout_reg;
        if (ofs_wr)
        begin
            if (ofs_wsel_reg == dcf_pkg::SEL_EMPTY_OFS)
            begin
                empty_threshold_offset_next = data_in_i[dcf_pkg::OFS_W-1:0];
            end
            else
            begin
                full_threshold_offset_next = data_in_i[dcf_pkg::OFS_W-1:0];
            end
            ofs_wsel_next = ~ofs_wsel_reg;
        end
        if (ofs_rd)
        begin
            if (ofs_rsel_reg == dcf_pkg::SEL_EMPTY_OFS)
            begin
                dout_next = {dcf_pkg::OFS_PAD, empty_threshold_offset_reg};
            end
            else
            begin
                dout_next = {dcf_pkg::OFS_PAD, full_threshold_offset_reg};
            end
            ofs_rsel_next = ~ofs_rsel_reg;
        end
        else if (rd_fire)
        begin
            dout_next = mem_rdata;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            empty_threshold_offset_reg <= dcf_pkg::OFS_DEFAULT;
            full_threshold_offset_reg  <= dcf_pkg::OFS_DEFAULT;
            ofs_wsel_reg               <= dcf_pkg::SEL_EMPTY_OFS;
            ofs_rsel_reg               <= dcf_pkg::SEL_EMPTY_OFS;
            dout_reg                   <= dcf_pkg::DOUT_RESET;
        end
        else
        begin
            empty_threshold_offset_reg <= empty_threshold_offset_next;
            full_threshold_offset_reg  <= full_threshold_offset_next;
            ofs_wsel_reg               <= ofs_wsel_next;
            ofs_rsel_reg               <= ofs_rsel_next;
            dout_reg                   <= dout_next;
        end
    end

    // ----------------------------------------------------------------
    // status flags and chain pulses
    // ----------------------------------------------------------------
    logic        full_n_next;
    logic        empty_n_next;
    logic        half_n_reg;
    logic        half_n_next;
    logic        afull_n_reg;
    logic        afull_n_next;
    logic        aempty_n_reg;
    logic        aempty_n_next;
    logic        wxo_n_reg;
    logic        wxo_n_next;
    logic        rxo_n_reg;
    logic        rxo_n_next;
    logic [12:0] fill_plus_m;

    assign fill_plus_m = {4'h0, count} + {1'b0, full_threshold_offset_reg};

    always_comb
    begin
        full_n_next   = full_n_reg;
        empty_n_next  = empty_n_reg;
        if (wr_edge)
        begin
            full_n_next = (count_new != dcf_pkg::DEPTH);
        end
        if (rd_edge)
        begin
            empty_n_next = (count_new != dcf_pkg::CNT_ZERO);
        end
        half_n_next   = ~(count > dcf_pkg::HALF_DEPTH);
        afull_n_next  = ~(fill_plus_m >= {4'h0, dcf_pkg::DEPTH});
        aempty_n_next = ~({4'h0, count} <= {1'b0, empty_threshold_offset_reg});
        wxo_n_next    = ~(wr_fire && wptr_reg[dcf_pkg::AW-1:0] == dcf_pkg::ADDR_LAST);
        rxo_n_next    = ~(rd_fire && rptr_reg[dcf_pkg::AW-1:0] == dcf_pkg::ADDR_LAST);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            full_n_reg   <= 1'b1;
            empty_n_reg  <= 1'b0;
            half_n_reg   <= 1'b1;
            afull_n_reg  <= 1'b1;
            aempty_n_reg <= 1'b0;
            wxo_n_reg    <= 1'b1;
            rxo_n_reg    <= 1'b1;
        end
        else
        begin
            full_n_reg   <= full_n_next;
            empty_n_reg  <= empty_n_next;
            half_n_reg   <= half_n_next;
            afull_n_reg  <= afull_n_next;
            aempty_n_reg <= aempty_n_next;
            wxo_n_reg    <= wxo_n_next;
            rxo_n_reg    <= rxo_n_next;
        end
    end

    assign data_out_o            = dout_reg;
    assign data_out_oe_o         = ~output_enable_n_i;
    assign full_flag_n_o         = full_n_reg;
    assign empty_flag_n_o        = empty_n_reg;
    assign half_full_flag_n_o    = half_n_reg;
    assign almost_full_flag_n_o  = afull_n_reg;
    assign almost_empty_flag_n_o = aempty_n_reg;
    assign write_chain_out_n_o   = wxo_n_reg;
    assign read_chain_out_n_o    = rxo_n_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ofs_write;
        wr_edge && !load_n_i && !write_enable_n_i;
    endsequence

    sequence s_blocked_write;
        wr_edge && !write_enable_n_i && load_n_i && !full_n_reg;
    endsequence

    a_full_blocks_write: assert property (s_blocked_write |=> wptr_reg == $past(wptr_reg))
        else $error("write taken while full");

    a_empty_blocks_read: assert property (rd_edge && !empty_n_reg |=> rptr_reg == $past(rptr_reg))
        else $error("read taken while empty");

    a_output_hold_idle: assert property (!rd_edge || read_enable_n_i |=> $stable(data_out_o))
        else $error("output register changed without read");

    a_full_at_depth: assert property (wr_edge && count_new == dcf_pkg::DEPTH |=> !full_flag_n_o)
        else $error("full flag missing at depth");

    a_empty_release: assert property (rd_edge && count_new != dcf_pkg::CNT_ZERO |=> empty_flag_n_o)
        else $error("empty flag not released");

    a_ofs_seq_step: assert property (s_ofs_write |=> ofs_wsel_reg != $past(ofs_wsel_reg))
        else $error("offset write selector did not advance");

    a_ofs_wr_frozen: assert property (wr_edge && !load_n_i && write_enable_n_i |=> $stable(ofs_wsel_reg) && $stable(empty_threshold_offset_reg))
        else $error("offset state moved with write disabled");

    a_ofs_read_empty: assert property (ofs_rd && ofs_rsel_reg == dcf_pkg::SEL_EMPTY_OFS |=> data_out_o == {dcf_pkg::OFS_PAD, $past(empty_threshold_offset_reg)})
        else $error("empty offset readback wrong");

    a_wrap_pulse: assert property (wr_fire && wptr_reg[dcf_pkg::AW-1:0] == dcf_pkg::ADDR_LAST |=> wptr_reg[dcf_pkg::AW-1:0] == dcf_pkg::ADDR_FIRST && !write_chain_out_n_o ##1 write_chain_out_n_o)
        else $error("wrap or chain pulse wrong");

endmodule

/* File: testbench/dcf_far_end.sv */
// writer and reader model facing the fifo control ports
module dcf_far_end (
    input  wire logic                      clk_i,
    output logic                           write_clk_o,
    output logic                           write_enable_n_o,
    output logic [dcf_pkg::DATA_W-1:0]     data_in_o,
    output logic                           read_clk_o,
    output logic                           read_enable_n_o,
    output logic                           load_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // port clocks stand low outside a cycle
    initial
    begin
        write_clk_o      = 1'b0;
        write_enable_n_o = 1'b1;
        data_in_o        = 18'h00000;
        read_clk_o       = 1'b0;
        read_enable_n_o  = 1'b1;
        load_n_o         = 1'b1;
    end

    // one write cycle; returns once the answer has settled
    task automatic port_write(input logic ld_n, input logic en_n,
                              input logic [dcf_pkg::DATA_W-1:0] d);
        @(negedge clk_i);
        load_n_o         = ld_n;
        write_enable_n_o = en_n;
        data_in_o        = d;
        @(negedge clk_i);
        write_clk_o = 1'b1;
        @(negedge clk_i);
        write_clk_o      = 1'b0;
        write_enable_n_o = 1'b1;
        load_n_o         = 1'b1;
        // released data no longer shows the word
        data_in_o = ~d;
        @(negedge clk_i);
    endtask

    // one read cycle; every word is asked for explicitly
    // load is shared, so offset reads and writes never overlap
    task automatic port_read(input logic ld_n, input logic en_n);
        @(negedge clk_i);
        load_n_o        = ld_n;
        read_enable_n_o = en_n;
        @(negedge clk_i);
        read_clk_o = 1'b1;
        @(negedge clk_i);
        read_clk_o      = 1'b0;
        read_enable_n_o = 1'b1;
        load_n_o        = 1'b1;
        @(negedge clk_i);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the dual-clock fifo control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         clk_i;
    logic                         rst_i;
    logic                         output_enable_n_i;
    logic                         write_clk_i;
    logic                         write_enable_n_i;
    logic [dcf_pkg::DATA_W-1:0]   data_in_i;
    logic                         read_clk_i;
    logic                         read_enable_n_i;
    logic                         load_n_i;
    logic [dcf_pkg::DATA_W-1:0]   data_out_o;
    logic                         data_out_oe_o;
    logic                         full_flag_n_o;
    logic                         empty_flag_n_o;
    logic                         half_full_flag_n_o;
    logic                         almost_full_flag_n_o;
    logic                         almost_empty_flag_n_o;
    logic                         write_chain_out_n_o;
    logic                         read_chain_out_n_o;
    int                           fails;
    int                           n_compared;
    int                           ptr;
    int                           base;
    // chain outputs pulse for one clk, long before a task returns; count them instead
    int                           n_wxo = 0;
    int                           n_rxo = 0;

    always @(posedge clk_i)
    begin
        if (!write_chain_out_n_o)
            n_wxo++;
        if (!read_chain_out_n_o)
            n_rxo++;
    end

    dcf_far_end i_dcf_far_end (
        .clk_i            (clk_i),
        .write_clk_o      (write_clk_i),
        .write_enable_n_o (write_enable_n_i),
        .data_in_o        (data_in_i),
        .read_clk_o       (read_clk_i),
        .read_enable_n_o  (read_enable_n_i),
        .load_n_o         (load_n_i)
    );

    // single-device straps
    dcf_fifo_ctrl i_dcf_fifo_ctrl (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .write_clk_i           (write_clk_i),
        .write_enable_n_i      (write_enable_n_i),
        .data_in_i             (data_in_i),
        .read_clk_i            (read_clk_i),
        .read_enable_n_i       (read_enable_n_i),
        .output_enable_n_i     (output_enable_n_i),
        .load_n_i              (load_n_i),
        .first_load_sel_i      (1'b0),
        .write_chain_in_n_i    (1'b0),
        .read_chain_in_n_i     (1'b0),
        .data_out_o            (data_out_o),
        .data_out_oe_o         (data_out_oe_o),
        .full_flag_n_o         (full_flag_n_o),
        .empty_flag_n_o        (empty_flag_n_o),
        .half_full_flag_n_o    (half_full_flag_n_o),
        .almost_full_flag_n_o  (almost_full_flag_n_o),
        .almost_empty_flag_n_o (almost_empty_flag_n_o),
        .write_chain_out_n_o   (write_chain_out_n_o),
        .read_chain_out_n_o    (read_chain_out_n_o)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_bit(input string what, input logic seen, input logic exp);
        check(what, {17'h00000, seen}, {17'h00000, exp});
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reset state is checked while reset still stands
    task automatic apply_reset;
        rst_i = 1'b1;
        repeat (20) @(negedge clk_i);
        chk_bit("full", full_flag_n_o, 1'b1);
        chk_bit("half_full", half_full_flag_n_o, 1'b1);
        chk_bit("almost_full", almost_full_flag_n_o, 1'b1);
        chk_bit("empty", empty_flag_n_o, 1'b0);
        chk_bit("almost_empty", almost_empty_flag_n_o, 1'b0);
        check("data_out", data_out_o, 18'h00000);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        i_dcf_far_end.port_read(1'b0, 1'b0);
        check("empty_ofs", data_out_o, 18'h0001F);
        i_dcf_far_end.port_read(1'b0, 1'b0);
        check("full_ofs", data_out_o, 18'h0001F);
        $display("test reset done");
    endtask

    task automatic wr(input logic [17:0] d);
        i_dcf_far_end.port_write(1'b1, 1'b0, d);
    endtask

    task automatic rd_word(input logic [17:0] e);
        i_dcf_far_end.port_read(1'b1, 1'b0);
        check("data_out", data_out_o, e);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // a full run takes about 2200 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        print_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        fails = 0;
        n_compared = 0;
        output_enable_n_i = 1'b0;
        apply_reset();
        wr(18'h2A5A5);
        wr(18'h15A5A);
        wr(18'h3FFFF);
        i_dcf_far_end.port_write(1'b1, 1'b1, 18'h01234);
        chk_bit("empty", empty_flag_n_o, 1'b0);
        i_dcf_far_end.port_read(1'b1, 1'b1);
        chk_bit("empty", empty_flag_n_o, 1'b1);
        check("data_out", data_out_o, 18'h0001F);
        rd_word(18'h2A5A5);
        rd_word(18'h15A5A);
        rd_word(18'h3FFFF);
        chk_bit("empty", empty_flag_n_o, 1'b0);
        i_dcf_far_end.port_read(1'b1, 1'b0);
        check("data_out", data_out_o, 18'h3FFFF);
        $display("test basic done");
        i_dcf_far_end.port_write(1'b0, 1'b0, 18'h00005);
        i_dcf_far_end.port_write(1'b0, 1'b1, 18'h00777);
        i_dcf_far_end.port_write(1'b0, 1'b0, 18'h0000A);
        i_dcf_far_end.port_write(1'b0, 1'b0, 18'h00003);
        i_dcf_far_end.port_read(1'b0, 1'b0);
        check("empty_ofs", data_out_o, 18'h00003);
        i_dcf_far_end.port_read(1'b0, 1'b1);
        check("ofs_hold", data_out_o, 18'h00003);
        i_dcf_far_end.port_read(1'b0, 1'b0);
        check("full_ofs", data_out_o, 18'h0000A);
        $display("test offsets done");
        ptr = 3;
        for (int i = 0; i < 256; i++)
        begin
            base = n_wxo;
            wr(18'h20000 + 18'(i));
            chk_bit("write_chain", n_wxo == base, ((ptr + i) % 256) != 255);
            chk_bit("half_full", half_full_flag_n_o, !(i + 1 > 128));
            chk_bit("almost_full", almost_full_flag_n_o, !(i + 1 >= 246));
            chk_bit("almost_empty", almost_empty_flag_n_o, !(i + 1 <= 3));
            chk_bit("full", full_flag_n_o, i != 255);
        end
        wr(18'h01111);
        chk_bit("full", full_flag_n_o, 1'b0);
        i_dcf_far_end.port_read(1'b1, 1'b1);
        for (int j = 0; j < 256; j++)
        begin
            base = n_rxo;
            rd_word(18'h20000 + 18'(j));
            chk_bit("read_chain", n_rxo == base, ((ptr + j) % 256) != 255);
            if (j == 0)
            begin
                chk_bit("full", full_flag_n_o, 1'b0);
                i_dcf_far_end.port_write(1'b1, 1'b1, 18'h00000);
                chk_bit("full", full_flag_n_o, 1'b1);
            end
        end
        chk_bit("empty", empty_flag_n_o, 1'b0);
        $display("test fill done");
        @(negedge clk_i);
        output_enable_n_i = 1'b1;
        @(negedge clk_i);
        chk_bit("oe", data_out_oe_o, 1'b0);
        output_enable_n_i = 1'b0;
        @(negedge clk_i);
        chk_bit("oe", data_out_oe_o, 1'b1);
        $display("test output enable done");
        wr(18'h00123);
        apply_reset();
        i_dcf_far_end.port_read(1'b1, 1'b1);
        chk_bit("empty", empty_flag_n_o, 1'b0);
        $display("test second reset done");
        print_verdict();
    end
endmodule
